// File: rtl/adcev_ctrl.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module adcev_ctrl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // conversion core events
  input wire logic core_ready_evt,
  input wire logic core_sample_done,
  input wire logic core_conv_done,
  input wire logic [15:0] core_result,
  input wire logic core_seq_done,
  input wire logic core_watch_evt,
  input wire logic [2:0] core_seg_done,
  input wire logic core_seg_valid,
  input wire logic [4:0] core_seg_slot,
  input wire logic [15:0] core_seg_data,
  input wire logic core_busy,
  // conversion core control
  output logic conv_run,
  output logic power_down,
  // dma handshake
  output logic dma_req,
  input wire logic dma_ack,
  // interrupt
  output logic irq
);
  import adcev_pkg::*;

  function automatic logic [4:0] plain_idx_f(input logic [11:0] a);
    case (a)
      OFF_CFG1: plain_idx_f = 5'h00;
      OFF_CFG2: plain_idx_f = 5'h01;
      OFF_SMPTIM: plain_idx_f = 5'h02;
      OFF_CFG3: plain_idx_f = 5'h03;
      OFF_AWDT: plain_idx_f = 5'h04;
      OFF_CHSEL: plain_idx_f = 5'h05;
      OFF_SEQCTL: plain_idx_f = 5'h06;
      OFF_SLOT1: plain_idx_f = 5'h07;
      OFF_SLOT2: plain_idx_f = 5'h08;
      OFF_SLOT3: plain_idx_f = 5'h09;
      OFF_SLOT4: plain_idx_f = 5'h0A;
      OFF_COMMON: plain_idx_f = 5'h0B;
      default: plain_idx_f = 5'h1F;
    endcase
  endfunction

  // registers
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_got_ff, w_got_ff;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [10:0] flags_ff, ien_ff;
  logic en_ff, start_ff, run_seen_ff, dma_halt_ff;
  logic [15:0] result_ff;
  logic [15:0] seg_ff [SEG_COUNT];
  logic [31:0] plain_ff [PLAIN_COUNT];
  logic dma_req_ff, power_down_ff, irq_ff;

  // write channel
  wire aw_hs = s_axi_awvalid & awready_ff;
  wire w_hs = s_axi_wvalid & wready_ff;
  wire have_aw = aw_got_ff | aw_hs;
  wire have_w = w_got_ff | w_hs;
  wire do_wr = have_aw & have_w & ~bvalid_ff;
  wire [11:0] wr_addr = aw_hs ? s_axi_awaddr : awaddr_ff;
  wire [31:0] wr_data = w_hs ? s_axi_wdata : wdata_ff;
  wire [3:0] wr_strb = w_hs ? s_axi_wstrb : wstrb_ff;
  wire [31:0] wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire nxt_aw_got = have_aw & ~do_wr;
  wire nxt_w_got = have_w & ~do_wr;
  wire nxt_bvalid = do_wr | (bvalid_ff & ~s_axi_bready);
  wire nxt_awready = ~nxt_aw_got & ~nxt_bvalid;
  wire nxt_wready = ~nxt_w_got & ~nxt_bvalid;

  // address decode, shared by both directions
  wire [4:0] wr_pidx = plain_idx_f(wr_addr);
  wire [4:0] rd_pidx = plain_idx_f(s_axi_araddr);
  wire [11:0] rd_seg_off = s_axi_araddr - OFF_SEG_BASE;
  wire rd_seg_hit = (s_axi_araddr >= OFF_SEG_BASE) && (s_axi_araddr <= OFF_SEG_LAST)
                    && (s_axi_araddr[1:0] == 2'h0);
  wire wr_seg_hit = (wr_addr >= OFF_SEG_BASE) && (wr_addr <= OFF_SEG_LAST)
                    && (wr_addr[1:0] == 2'h0);
  wire wr_status = do_wr && (wr_addr == OFF_STATUS);
  wire wr_ien = do_wr && (wr_addr == OFF_IEN);
  wire wr_ctrl = do_wr && (wr_addr == OFF_CTRL);
  wire wr_plain = do_wr && (wr_pidx != 5'h1F);
  wire wr_cfg1 = wr_plain && (wr_pidx[3:0] == PIDX_CFG1);
  wire wr_hit = (wr_addr == OFF_STATUS) || (wr_addr == OFF_IEN) || (wr_addr == OFF_CTRL)
                || (wr_addr == OFF_RESULT) || wr_seg_hit || (wr_pidx != 5'h1F);
  wire [31:0] plain_cur = wr_plain ? plain_ff[wr_pidx[3:0]] : RST_WORD;
  wire [31:0] plain_new = (plain_cur & ~wmask) | (wr_data & wmask);
  wire [31:0] ien_new = ({21'h0, ien_ff} & ~wmask) | (wr_data & wmask);
  wire [31:0] wr_ctl_bits = wr_data & wmask;

  // configuration fields
  wire [31:0] cfg1 = plain_ff[PIDX_CFG1];
  wire dma_en = cfg1[CFG_DMA_EN];
  wire dma_circ = cfg1[CFG_DMA_MODE];
  wire ovr_policy = cfg1[CFG_OVR_POLICY];
  wire auto_off = cfg1[CFG_AUTO_OFF];
  // the conversion count itself stays in the sequence control register; no port passes it to the core
  wire seg_mode = plain_ff[PIDX_SEQCTL][SEQ_SEG_EN]; // R18

  // read channel
  wire ar_hs = s_axi_arvalid & arready_ff;
  wire rd_result = ar_hs && (s_axi_araddr == OFF_RESULT);
  wire nxt_rvalid = ar_hs | (rvalid_ff & ~s_axi_rready);
  wire rd_plain_hit = (rd_pidx != 5'h1F);
  wire [31:0] rd_plain = rd_plain_hit ? plain_ff[rd_pidx[3:0]] : RST_WORD;
  wire [31:0] rd_seg = rd_seg_hit ? {16'h0, seg_ff[rd_seg_off[6:2]]} : RST_WORD;
  wire [31:0] rd_ctrl = {29'h0, start_ff, 1'b0, en_ff};
  wire rd_hit = (s_axi_araddr == OFF_STATUS) || (s_axi_araddr == OFF_IEN)
                || (s_axi_araddr == OFF_CTRL) || (s_axi_araddr == OFF_RESULT)
                || rd_seg_hit || rd_plain_hit;
  wire [31:0] rd_word = (s_axi_araddr == OFF_STATUS) ? {21'h0, flags_ff} :
                        (s_axi_araddr == OFF_IEN) ? {21'h0, ien_ff} :
                        (s_axi_araddr == OFF_CTRL) ? rd_ctrl :
                        (s_axi_araddr == OFF_RESULT) ? {16'h0, result_ff} :
                        rd_seg_hit ? rd_seg : rd_plain;

  // conversion and overrun; an unserviced dma request counts like an unread result
  wire ovr_evt = core_conv_done & (flags_ff[FLG_CONV] | dma_req_ff); // R2 R10
  wire take_result = core_conv_done & (~ovr_evt | ovr_policy); // R4 R5 R7
  wire dma_allowed = dma_en & ~seg_mode & ~flags_ff[FLG_OVR] & ~dma_halt_ff; // R9 R10 R11

  // event flags: set wins over the write-one clear and the result-read clear
  wire [10:0] evt_set;
  assign evt_set[FLG_READY] = core_ready_evt;
  assign evt_set[FLG_SAMPLE] = core_sample_done;
  assign evt_set[FLG_CONV] = core_conv_done; // R7
  assign evt_set[FLG_SEQ] = core_seq_done;
  assign evt_set[FLG_OVR] = ovr_evt; // R2
  assign evt_set[6:5] = 2'h0;
  assign evt_set[FLG_WATCH] = core_watch_evt;
  assign evt_set[FLG_SEG3] = core_seg_done[2];
  assign evt_set[FLG_SEG1] = core_seg_done[0];
  assign evt_set[FLG_SEG2] = core_seg_done[1]; // R1
  wire [10:0] flag_clr = (wr_status ? (wr_ctl_bits[10:0] & EVT_MASK) : 11'h000)
                         | {8'h00, rd_result, 2'h0};
  wire [10:0] nxt_flags = ((flags_ff & ~flag_clr) | evt_set) & EVT_MASK; // R19

  // control register: enable, disable, start, stop
  // disable is refused while the start bit is set; core_busy is not checked, so a conversion still running after stop can be cut off
  wire ctrl_idle = ~en_ff & ~start_ff;
  wire set_en = wr_ctrl & wr_ctl_bits[CTL_ENABLE] & ctrl_idle;
  wire set_dis = wr_ctrl & wr_ctl_bits[CTL_DISABLE] & en_ff & ~start_ff;
  wire set_start = wr_ctrl & wr_ctl_bits[CTL_START] & en_ff & ~wr_ctl_bits[CTL_DISABLE];
  wire set_stop = wr_ctrl & wr_ctl_bits[CTL_STOP];
  // hold policy halts conversion so the unread result survives
  wire ovr_halt = ovr_evt & ~ovr_policy; // R6
  wire nxt_en = (en_ff | set_en) & ~set_dis;
  wire nxt_start = (start_ff | set_start) & ~set_stop & ~set_dis & ~ovr_halt; // R6
  wire restart = set_start & ~start_ff & run_seen_ff;
  // single-mode halt lifts only when config_one is rewritten, i.e. dma is set up anew
  wire nxt_dma_halt = (dma_halt_ff | (restart & ~dma_circ)) & ~wr_cfg1; // R12 R14
  wire nxt_dma_req = (dma_req_ff & ~dma_ack & ~rd_result)
                     | (take_result & dma_allowed); // R9
  wire nxt_power_down = ~nxt_en | (auto_off & ~seg_mode & ~nxt_start & ~core_busy); // R15 R16
  // irq follows the flags at the same edge, so a write-one clear drops it at once
  wire nxt_irq = |(nxt_flags & ien_ff); // R3 R21

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= 12'h000;
      wdata_ff <= RST_WORD;
      wstrb_ff <= 4'h0;
    end else begin
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      bvalid_ff <= nxt_bvalid;
      if (do_wr) begin
        bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (aw_hs) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= RST_WORD;
      rresp_ff <= RESP_OKAY;
    end else begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_hs) begin
        rdata_ff <= rd_hit ? rd_word : RST_WORD;
        rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_ff <= 11'h000;
      ien_ff <= 11'h000;
      en_ff <= 1'b0;
      start_ff <= 1'b0;
      run_seen_ff <= 1'b0;
      dma_halt_ff <= 1'b0;
      dma_req_ff <= 1'b0;
      power_down_ff <= 1'b1;
      irq_ff <= 1'b0;
      result_ff <= 16'h0000;
    end else begin
      flags_ff <= nxt_flags;
      // enables frozen while conversion is running
      if (wr_ien && !start_ff) begin
        ien_ff <= ien_new[10:0] & EVT_MASK; // R20
      end
      en_ff <= nxt_en;
      start_ff <= nxt_start;
      run_seen_ff <= run_seen_ff | set_start;
      dma_halt_ff <= nxt_dma_halt;
      dma_req_ff <= nxt_dma_req;
      power_down_ff <= nxt_power_down;
      irq_ff <= nxt_irq;
      if (take_result) begin
        result_ff <= core_result; // R4 R5
      end
    end
  end

  // plain configuration storage and segment results
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < PLAIN_COUNT; i++) begin
        plain_ff[i] <= RST_WORD;
      end
      for (int i = 0; i < SEG_COUNT; i++) begin
        seg_ff[i] <= 16'h0000;
      end
    end else begin
      if (wr_plain) begin
        plain_ff[wr_pidx[3:0]] <= plain_new;
      end
      if (core_seg_valid && (core_seg_slot < 5'(SEG_COUNT))) begin
        seg_ff[core_seg_slot] <= core_seg_data; // R17
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign conv_run = start_ff;
  assign power_down = power_down_ff;
  assign dma_req = dma_req_ff;
  assign irq = irq_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_overrun_sets: assert property (core_conv_done && flags_ff[FLG_CONV] |=> flags_ff[FLG_OVR]) // R2
    else $error("overrun flag not set");
  a_overrun_irq: assert property (flags_ff[FLG_OVR] && $past(ien_ff[FLG_OVR]) |-> irq_ff) // R3
    else $error("overrun interrupt missing");
  a_result_hold: assert property (core_conv_done && flags_ff[FLG_CONV] && !ovr_policy // R4
    |=> result_ff == $past(result_ff))
    else $error("held result overwritten");
  a_result_overwrite: assert property (core_conv_done && ovr_policy // R5
    |=> result_ff == $past(core_result))
    else $error("result not overwritten");
  a_keep_running: assert property (start_ff && ovr_evt && ovr_policy && !wr_ctrl |=> start_ff) // R6
    else $error("conversion stopped on overwrite overrun");
  a_conv_flag: assert property (core_conv_done |=> flags_ff[FLG_CONV]) // R7
    else $error("conversion flag not set");
  a_dma_blocked: assert property (flags_ff[FLG_OVR] && !dma_req_ff |=> !dma_req_ff) // R10
    else $error("dma request during overrun");
  a_seg_no_dma: assert property (seg_mode && !dma_req_ff |=> !dma_req_ff) // R11
    else $error("dma request in segmented mode");
  a_dma_after: assert property (take_result && dma_allowed |=> dma_req_ff) // R9
    else $error("dma request missing");
  a_power_off: assert property (en_ff && auto_off && !seg_mode && !start_ff && !core_busy // R15
    && !wr_ctrl |=> power_down_ff)
    else $error("converter not powered down");
  a_seg_awake: assert property (seg_mode && en_ff && !wr_ctrl && !wr_plain |=> !power_down_ff) // R16
    else $error("auto power-off in segmented mode");
  a_ien_locked: assert property (start_ff |=> $stable(ien_ff)) // R20
    else $error("enables changed while running");
  a_irq_or: assert property (irq_ff == |(flags_ff & $past(ien_ff))) // R21
    else $error("interrupt not the or of enabled flags");
  a_flag_sticky: assert property (!wr_status && !rd_result |=> (flags_ff & $past(flags_ff)) // R19
    == $past(flags_ff))
    else $error("flag dropped without clear");
  a_single_halt: assert property (dma_halt_ff && !dma_req_ff |=> !dma_req_ff) // R12
    else $error("dma request after single-mode restart");
  a_circ_keeps: assert property (restart && dma_circ && !dma_halt_ff |=> !dma_halt_ff) // R14
    else $error("circular mode halted on restart");
  a_seg_store: assert property (core_seg_valid && core_seg_slot == 5'(SEG_COUNT - 1) // R17
    |=> seg_ff[SEG_COUNT - 1] == $past(core_seg_data))
    else $error("segment result not stored");

  c_overwrite: cover property (ovr_evt && ovr_policy && start_ff);
  c_dma_ack: cover property (dma_req_ff ##[1:20] dma_ack);
  c_seg_store: cover property (core_seg_valid && seg_mode);
  c_restart: cover property (restart && !dma_circ);
  c_ovr_hold: cover property (ovr_halt && start_ff);
endmodule

// File: pkg/adcev_pkg.sv
// Notes on behaviour
// R1: nine event flags, each with enable bit
// R2: conversion while done flag set sets overrun
// R3: overrun flag with enable raises interrupt
// R4: policy zero keeps old result on overrun
// R5: policy one overwrites result with newest
// R6: policy one overrun does not stop conversion
// R7: each conversion sets done flag, loads result
// R8: software without DMA keeps policy at zero
// R9: DMA enabled: request after each conversion
// R10: unserviced DMA gives overrun, blocks further requests
// R11: no DMA in segmented sampling mode
// R12: single mode: requests stop after restart
// R13: software stops converter at DMA length
// R14: circular mode keeps requesting after restart
// R15: auto power-off when idle, wake on start
// R16: no auto power-off in segmented mode
// R17: nineteen segment results at 0x44 plus 4x
// R18: conversion count comes from sequence control
// R19: hardware sets flags, software writes one clears
// R20: enables writable only while start bit zero
// R21: interrupt is OR of enabled flags
package adcev_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_STATUS = 12'h000;
  localparam logic [11:0] OFF_IEN = 12'h004;
  localparam logic [11:0] OFF_CTRL = 12'h008;
  localparam logic [11:0] OFF_CFG1 = 12'h00C;
  localparam logic [11:0] OFF_CFG2 = 12'h010;
  localparam logic [11:0] OFF_SMPTIM = 12'h014;
  localparam logic [11:0] OFF_CFG3 = 12'h018;
  localparam logic [11:0] OFF_AWDT = 12'h020;
  localparam logic [11:0] OFF_CHSEL = 12'h028;
  localparam logic [11:0] OFF_RESULT = 12'h040;
  localparam logic [11:0] OFF_SEG_BASE = 12'h044;
  localparam logic [11:0] OFF_SEG_LAST = 12'h08C;
  localparam logic [11:0] OFF_SEQCTL = 12'h100;
  localparam logic [11:0] OFF_SLOT1 = 12'h104;
  localparam logic [11:0] OFF_SLOT2 = 12'h108;
  localparam logic [11:0] OFF_SLOT3 = 12'h10C;
  localparam logic [11:0] OFF_SLOT4 = 12'h110;
  localparam logic [11:0] OFF_COMMON = 12'h308;
  localparam int SEG_COUNT = 19;
  localparam int PLAIN_COUNT = 12;
  localparam logic [3:0] PIDX_CFG1 = 4'h0;
  localparam logic [3:0] PIDX_SEQCTL = 4'h6;
  // status / enable bit positions
  localparam int FLG_READY = 0;
  localparam int FLG_SAMPLE = 1;
  localparam int FLG_CONV = 2;
  localparam int FLG_SEQ = 3;
  localparam int FLG_OVR = 4;
  localparam int FLG_WATCH = 7;
  localparam int FLG_SEG3 = 8;
  localparam int FLG_SEG1 = 9;
  localparam int FLG_SEG2 = 10;
  localparam logic [10:0] EVT_MASK = 11'h79F;
  // control bits
  localparam int CTL_ENABLE = 0;
  localparam int CTL_DISABLE = 1;
  localparam int CTL_START = 2;
  localparam int CTL_STOP = 4;
  // config_one bits
  localparam int CFG_DMA_EN = 0;
  localparam int CFG_DMA_MODE = 1;
  localparam int CFG_OVR_POLICY = 12;
  localparam int CFG_AUTO_OFF = 15;
  // segment_sequence_control bits
  localparam int SEQ_SEG_EN = 0;
  // reset values and bus answers
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: tb/adcev_core_model.sv
`timescale 1ns/10ps
module adcev_core_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // commands from the bench
  input wire logic go_conv,
  input wire logic [15:0] go_data,
  input wire logic [7:0] go_evt,
  input wire logic ack_en,
  // conversion core side
  output logic core_ready_evt,
  output logic core_sample_done,
  output logic core_conv_done,
  output logic [15:0] core_result,
  output logic core_seq_done,
  output logic core_watch_evt,
  output logic [2:0] core_seg_done,
  output logic core_seg_valid,
  output logic [4:0] core_seg_slot,
  output logic [15:0] core_seg_data,
  output logic core_busy,
  // dma controller side
  input wire logic dma_req,
  output logic dma_ack
);
  logic [1:0] busy_ff = 2'h0;
  logic [15:0] data_ff = 16'h0000;
  logic [7:0] evt_ff = 8'h00;
  logic ack_ff = 1'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_ff <= 2'h0;
      evt_ff <= 8'h00;
      ack_ff <= 1'h0;
    end else begin
      busy_ff <= go_conv ? 2'h2 : busy_ff - {1'h0, |busy_ff};
      data_ff <= (go_conv | go_evt[7]) ? go_data : data_ff;
      evt_ff <= go_evt;
      // with ack_en low the controller stalls and the request stays pending
      ack_ff <= dma_req & ack_en & ~ack_ff;
    end
  end
  assign core_conv_done = busy_ff == 2'h1;
  assign core_busy = |busy_ff;
  // data lines carry meaning only in their strobe cycle, garbage otherwise
  assign core_result = core_conv_done ? data_ff : ~data_ff;
  assign core_ready_evt = evt_ff[0];
  assign core_sample_done = evt_ff[1];
  assign core_seq_done = evt_ff[2];
  assign core_watch_evt = evt_ff[3];
  assign core_seg_done = evt_ff[6:4];
  assign core_seg_valid = evt_ff[7];
  assign core_seg_slot = 5'h12;
  assign core_seg_data = core_seg_valid ? data_ff : ~data_ff;
  assign dma_ack = ack_ff;
endmodule

// File: tb/tb_adc_event_overrun_dma_ctrl.sv
`timescale 1ns/10ps
module tb_adc_event_overrun_dma_ctrl;
  import adcev_pkg::*;
  localparam logic [31:0] M_ALL = {21'h0, EVT_MASK};
  localparam logic [31:0] M_CONV = 32'h1 << FLG_CONV;
  localparam logic [31:0] M_OVR = 32'h1 << FLG_OVR;
  localparam logic [31:0] M_POL = 32'h1 << CFG_OVR_POLICY;
  localparam logic [31:0] M_DMA = 32'h1 << CFG_DMA_EN;
  localparam logic [31:0] M_START = 32'h1 << CTL_START;
  localparam logic [31:0] M_STOP = 32'h1 << CTL_STOP;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic go_conv = 1'h0, ack_en = 1'h0;
  logic [15:0] go_data = 16'h0000;
  logic [7:0] go_evt = 8'h00;
  logic rdy_e, smp_e, cnv_e, seq_e, wat_e, sg_v, busy, conv_run, power_down, dma_req, dma_ack, irq;
  logic [15:0] result, sg_data;
  logic [2:0] sg_done;
  logic [4:0] sg_slot;
  logic [3:0] snap;
  int n_mismatch = 0;
  int cmp_count = 0;
  always #12.5 aclk = ~aclk;
  // outputs are looked at between edges, never in the edge's own time step
  always @(negedge aclk) snap = {dma_req, irq, conv_run, power_down};
  adcev_ctrl u_adcev_ctrl (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'h1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
    .core_ready_evt(rdy_e), .core_sample_done(smp_e), .core_conv_done(cnv_e),
    .core_result(result), .core_seq_done(seq_e), .core_watch_evt(wat_e),
    .core_seg_done(sg_done), .core_seg_valid(sg_v), .core_seg_slot(sg_slot),
    .core_seg_data(sg_data), .core_busy(busy), .conv_run(conv_run),
    .power_down(power_down), .dma_req(dma_req), .dma_ack(dma_ack), .irq(irq));
  adcev_core_model u_adcev_core_model (
    .aclk(aclk), .aresetn(aresetn), .go_conv(go_conv), .go_data(go_data),
    .go_evt(go_evt), .ack_en(ack_en), .core_ready_evt(rdy_e), .core_sample_done(smp_e),
    .core_conv_done(cnv_e), .core_result(result), .core_seq_done(seq_e),
    .core_watch_evt(wat_e), .core_seg_done(sg_done), .core_seg_valid(sg_v),
    .core_seg_slot(sg_slot), .core_seg_data(sg_data), .core_busy(busy),
    .dma_req(dma_req), .dma_ack(dma_ack));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      n_mismatch++;
    end
  endtask
  task automatic chkb(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic aw_t, w_t, b_t;
    logic [1:0] r;
    b_t = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!b_t) begin
      @(negedge aclk);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_t) begin
        awvalid <= 1'h0;
        awaddr <= ~a;
      end
      if (w_t) begin
        wvalid <= 1'h0;
        wdata <= ~d;
      end
    end
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    logic ar_t, r_t;
    logic [31:0] d;
    logic [1:0] r;
    r_t = 1'h0;
    araddr <= a;
    arvalid <= 1'h1;
    while (!r_t) begin
      @(negedge aclk);
      ar_t = arvalid & arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_t) begin
        arvalid <= 1'h0;
        araddr <= ~a;
      end
    end
    chk("rdata", e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic conv(input logic [15:0] d);
    go_conv <= 1'h1;
    go_data <= d;
    @(posedge aclk);
    go_conv <= 1'h0;
    cyc(4);
  endtask
  task automatic evt(input logic [7:0] m, input logic [15:0] d);
    go_evt <= m;
    go_data <= d;
    @(posedge aclk);
    go_evt <= 8'h00;
    cyc(3);
  endtask
  task automatic t_reset();
    chkb("power_down", 1'h1, snap[0]);
    chkb("irq", 1'h0, snap[2]);
    rd(OFF_STATUS, RST_WORD);
    rd(OFF_IEN, RST_WORD);
    rd(12'h030, RST_WORD, RESP_SLVERR);
    wr(12'h031, 32'hFFFF_FFFF, RESP_SLVERR);
  endtask
  task automatic t_events();
    int pos [7];
    pos = '{FLG_READY, FLG_SAMPLE, FLG_SEQ, FLG_WATCH, FLG_SEG1, FLG_SEG2, FLG_SEG3};
    wr(OFF_IEN, M_ALL);
    rd(OFF_IEN, M_ALL);
    for (int i = 0; i < 7; i++) begin
      evt(8'h01 << i, 16'h0000);
      chkb("irq", 1'h1, snap[2]);
      rd(OFF_STATUS, 32'h1 << pos[i]);
      wr(OFF_STATUS, 32'h1 << pos[i]);
      cyc(2);
      chkb("irq", 1'h0, snap[2]);
      rd(OFF_STATUS, RST_WORD);
    end
    evt(8'h01, 16'h0000);
    wr(OFF_STATUS, RST_WORD);
    rd(OFF_STATUS, 32'h1 << FLG_READY);
    wr(OFF_STATUS, M_ALL);
  endtask
  task automatic t_hold();
    // software-read flow keeps the hold policy
    wr(OFF_IEN, M_OVR);
    wr(OFF_CTRL, 32'h1 << CTL_ENABLE);
    wr(OFF_CTRL, M_START);
    wr(OFF_IEN, M_ALL);
    rd(OFF_IEN, M_OVR);
    cyc(2);
    chkb("conv_run", 1'h1, snap[1]);
    chkb("power_down", 1'h0, snap[0]);
    conv(16'h1234);
    chkb("irq", 1'h0, snap[2]);
    conv(16'h5678);
    chkb("irq", 1'h1, snap[2]);
    rd(OFF_STATUS, M_CONV | M_OVR);
    rd(OFF_RESULT, 32'h0000_1234);
    wr(OFF_STATUS, M_ALL);
    cyc(2);
    chkb("irq", 1'h0, snap[2]);
  endtask
  task automatic t_keep();
    wr(OFF_CFG1, M_POL);
    wr(OFF_CTRL, M_START);
    conv(16'h1111);
    conv(16'h2222);
    chkb("conv_run", 1'h1, snap[1]);
    rd(OFF_STATUS, M_CONV | M_OVR);
    rd(OFF_RESULT, 32'h0000_2222);
    wr(OFF_STATUS, M_ALL);
  endtask
  task automatic t_dma();
    wr(OFF_CFG1, M_POL | M_DMA | (32'h1 << CFG_DMA_MODE));
    conv(16'h0A0A);
    chkb("dma_req", 1'h1, snap[3]);
    ack_en <= 1'h1;
    cyc(4);
    chkb("dma_req", 1'h0, snap[3]);
    ack_en <= 1'h0;
    wr(OFF_STATUS, M_CONV);
    conv(16'h0B0B);
    conv(16'h0C0C);
    rd(OFF_STATUS, M_CONV | M_OVR);
    ack_en <= 1'h1;
    cyc(4);
    ack_en <= 1'h0;
    wr(OFF_STATUS, M_CONV);
    conv(16'h0D0D);
    chkb("dma_req", 1'h0, snap[3]);
    wr(OFF_STATUS, M_ALL);
    conv(16'h0E0E);
    chkb("dma_req", 1'h1, snap[3]);
    rd(OFF_RESULT, 32'h0000_0E0E);
    wr(OFF_CTRL, M_STOP);
    wr(OFF_CTRL, M_START);
    conv(16'h0F0F);
    chkb("dma_req", 1'h1, snap[3]);
    rd(OFF_RESULT, 32'h0000_0F0F);
    wr(OFF_CFG1, M_POL | M_DMA);
    conv(16'h1010);
    chkb("dma_req", 1'h1, snap[3]);
    rd(OFF_RESULT, 32'h0000_1010);
    wr(OFF_CTRL, M_STOP);
    wr(OFF_CTRL, M_START);
    conv(16'h1111);
    chkb("dma_req", 1'h0, snap[3]);
    rd(OFF_RESULT, 32'h0000_1111);
  endtask
  task automatic t_power_seg();
    wr(OFF_CTRL, M_STOP);
    wr(OFF_CFG1, 32'h1 << CFG_AUTO_OFF);
    cyc(2);
    chkb("power_down", 1'h1, snap[0]);
    wr(OFF_CTRL, M_START);
    cyc(2);
    chkb("power_down", 1'h0, snap[0]);
    wr(OFF_CTRL, M_STOP);
    wr(OFF_SEQCTL, 32'h1 << SEQ_SEG_EN);
    cyc(2);
    chkb("power_down", 1'h0, snap[0]);
    rd(OFF_SEQCTL, 32'h1 << SEQ_SEG_EN);
    wr(OFF_CFG1, M_DMA);
    wr(OFF_CTRL, M_START);
    conv(16'h2020);
    chkb("dma_req", 1'h0, snap[3]);
    evt(8'h80, 16'hABCD);
    rd(OFF_SEG_LAST, 32'h0000_ABCD);
    rd(OFF_SEG_BASE, RST_WORD);
    rd(12'h090, RST_WORD, RESP_SLVERR);
    wr(OFF_CTRL, M_STOP);
    wr(OFF_CTRL, 32'h1 << CTL_DISABLE);
    cyc(2);
    chkb("power_down", 1'h1, snap[0]);
    rd(OFF_CTRL, RST_WORD);
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    cyc(5000);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    cyc(5);
    aresetn <= 1'h1;
    cyc(1);
    t_reset();
    t_events();
    t_hold();
    t_keep();
    t_dma();
    t_power_seg();
    end_of_test();
  end
endmodule
